// file: hw/ctf_pkg.sv
// Shared constants and types of the fault-limit register bank.
// Assumes a single 20 MHz clock and a synchronous active-high reset.
package ctf_pkg;
   // Command codes of the limit and response registers.
   localparam logic [7:0] CMD_OC_LIMIT = 8'h46;
   localparam logic [7:0] CMD_UC_LIMIT = 8'h4b;
   localparam logic [7:0] CMD_OT_LIMIT = 8'h4f;
   localparam logic [7:0] CMD_OT_ACTION = 8'h50;
   localparam logic [7:0] CMD_OT_WARN = 8'h51;
   // Reset values.
   localparam logic [15:0] OT_LIMIT_RST = 16'hebe8;
   localparam logic [15:0] OT_WARN_RST = 16'heb70;
   localparam logic [7:0] OT_ACTION_RST = 8'hbf;
   // Linear-11 fields.
   localparam int EXP_HI = 15;
   localparam int EXP_LO = 11;
   localparam int MANT_HI = 10;
   localparam logic [10:0] MANT_MIN = 11'h400;
   localparam logic [10:0] MANT_MAX = 11'h3ff;
   // Response byte fields and codes.
   localparam int MODE_HI = 7;
   localparam int MODE_LO = 6;
   localparam int RETRY_HI = 5;
   localparam int RETRY_LO = 3;
   localparam int DELAY_HI = 2;
   localparam int DELAY_LO = 0;
   localparam logic [1:0] MODE_RESUME = 2'h3;
   localparam logic [2:0] RETRY_CONT = 3'h7;
   // Timing.
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam int unsigned RETRY_UNIT_MS = 35;
   localparam int unsigned RETRY_UNIT_CYC = CLK_HZ / 1000 * RETRY_UNIT_MS;
   localparam int unsigned RUN_W = 4;
   // Fixed point with 16 fraction bits covers every Linear-11 value exactly.
   localparam int FX_W = 44;
   typedef logic signed [FX_W-1:0] ctf_fx_t;
   typedef enum logic [2:0] {ST_RUN, ST_COOL, ST_DELAY, ST_LATCH, ST_STOP} ctf_seq_state_t;
endpackage

// file: hw/ctf_seq_if.sv
// Signals between the register bank and the over-temperature sequencer.
// Assumes both ends run on the same clock.
interface ctf_seq_if;
   logic ot_above;
   logic below_warn;
   logic run_ok;
   logic clear;
   logic [7:0] action;
   logic out_en;
   logic ot_event;
   modport ctrl(output ot_above, below_warn, run_ok, clear, action, input out_en, ot_event);
   modport seq(input ot_above, below_warn, run_ok, clear, action, output out_en, ot_event);
endinterface

// file: hw/ctf_ot_seq.sv
// Over-temperature response sequencer: disable, latch, resume or timed retry.
// Assumes temperature compare levels are already on this clock.
module ctf_ot_seq #(
   parameter int unsigned UNIT_CYC = ctf_pkg::RETRY_UNIT_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Bank side
   ctf_seq_if.seq s
);
   import ctf_pkg::*;

   ctf_seq_state_t state_q, state_d;
   logic [31:0] timer_q, timer_d;
   logic out_en_q;
   logic [31:0] dly_cnt_q, dly_span_q;

   wire mode_resume = s.action[MODE_HI:MODE_LO] == MODE_RESUME;
   wire retry_cont = s.action[RETRY_HI:RETRY_LO] == RETRY_CONT;
   wire [31:0] delay_cyc = 32'(({29'h0, s.action[DELAY_HI:DELAY_LO]} + 32'h1) * UNIT_CYC);
   wire fault_now = state_q == ST_RUN && s.ot_above && s.run_ok;

   assign s.ot_event = fault_now;
   assign s.out_en = out_en_q;

   always_comb begin
      state_d = state_q;
      timer_d = timer_q;
      case (state_q)
         ST_RUN: begin
            if (!s.run_ok) state_d = ST_STOP;
            else if (s.ot_above) state_d = (mode_resume || retry_cont) ? ST_COOL : ST_LATCH;
         end
         ST_COOL: begin
            if (!s.run_ok) state_d = ST_STOP;
            else if (s.below_warn) begin
               state_d = mode_resume ? ST_RUN : ST_DELAY;
               timer_d = delay_cyc;
            end
         end
         ST_DELAY: begin
            if (!s.run_ok) state_d = ST_STOP;
            else if (timer_q <= 32'h1) state_d = ST_RUN;
            timer_d = timer_q - 32'h1;
         end
         ST_LATCH: begin
            if (s.clear) state_d = ST_STOP;
         end
         ST_STOP: begin
            if (s.run_ok) state_d = ST_RUN;
         end
         default: state_d = ST_STOP;
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state_q <= ST_STOP;
         timer_q <= 32'h0;
         out_en_q <= 1'b0;
      end else begin
         state_q <= state_d;
         timer_q <= timer_d;
         out_en_q <= state_d == ST_RUN;
      end
   end

   // Helper counters for the delay check only.
   always_ff @(posedge clk) begin
      if (reset) begin
         dly_cnt_q <= 32'h0;
         dly_span_q <= 32'h0;
      end else begin
         dly_cnt_q <= (state_q == ST_DELAY) ? dly_cnt_q + 32'h1 : 32'h0;
         if (state_q == ST_COOL && state_d == ST_DELAY) dly_span_q <= delay_cyc;
      end
   end

   AST_FAULT_DISABLES: assert property (
      @(posedge clk) disable iff (reset) fault_now |=> !s.out_en)
      else $error("Output stayed enabled after an over-temperature fault.");
   AST_LATCH_HOLDS: assert property (
      @(posedge clk) disable iff (reset) (state_q == ST_LATCH && !s.clear) |=> !s.out_en && state_q == ST_LATCH)
      else $error("Latched-off output restarted without a clear.");
   AST_WAIT_COOL: assert property (
      @(posedge clk) disable iff (reset) (state_q == ST_COOL && !s.below_warn && s.run_ok) |=> state_q == ST_COOL)
      else $error("Restart began while still above the warning limit.");
   AST_RESUME_FAST: assert property (
      @(posedge clk) disable iff (reset)
      (state_q == ST_COOL && mode_resume && s.below_warn && s.run_ok) |=> s.out_en)
      else $error("Resume mode did not re-enable below the warning limit.");
   AST_RETRY_SPAN: assert property (
      @(posedge clk) disable iff (reset) (state_q == ST_DELAY && state_d == ST_RUN) |-> dly_cnt_q + 32'h1 == dly_span_q)
      else $error("Retry delay length differs from the programmed span.");
   AST_CMD_OFF: assert property (
      @(posedge clk) disable iff (reset) !s.run_ok |=> !s.out_en ##1 (s.run_ok || !s.out_en))
      else $error("Output enabled while commanded off.");
endmodule // ctf_ot_seq

// file: hw/ctf_fault_limits.sv
// Fault-limit command registers with current and temperature fault detection.
// Assumes a command engine on the same clock delivers decoded register
// accesses, and telemetry arrives as Linear-11 words on the same clock.
// Operation
// - Peak limit checks only post-blanking samples.
// - Overcurrent fault needs configured consecutive exceeding samples.
// - Peak and averaged overcurrent share flag, action.
// - Peak limit two-byte RW, loads from strap.
// - Valley limit checks only post-blanking samples.
// - Undercurrent fault needs configured consecutive crossings.
// - Valley and averaged undercurrent share flag, action.
// - Valley limit loads negated strap limit.
// - Limits are Linear-11 mantissa times two-power.
// - Temperature above fault limit flags over-temperature.
// - Over-temperature limit resets to 125 C word.
// - Response byte resets to continuous retry, longest delay.
// - Fault pulls alert low, latches until clear.
// - Mode 10 disables output then follows retry.
// - Mode 11 resumes below warning limit.
// - Retry 000 stays off until cleared.
// - Retry 111 repeats until commanded off.
// - Each retry waits until below warning limit.
// - Retry spacing is delay field plus one, 35 ms.
// - Warning limit resets to 110 C word.
module ctf_fault_limits #(
   parameter int unsigned RETRY_UNIT_CYC = ctf_pkg::RETRY_UNIT_CYC,
   parameter int unsigned RUN_W = ctf_pkg::RUN_W
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Register command port
   input wire logic cmd_valid,
   input wire logic cmd_write,
   input wire logic [7:0] cmd_code,
   input wire logic [15:0] cmd_wdata,
   output logic [15:0] cmd_rdata,
   output logic cmd_ack,
   output logic cmd_nack,
   input wire logic clear_faults,
   // Current telemetry
   input wire logic iout_valid,
   input wire logic [15:0] iout_word,
   input wire logic blank_done,
   input wire logic [RUN_W-1:0] consec_samples,
   input wire logic avg_oc_trip,
   input wire logic avg_uc_trip,
   // Temperature telemetry
   input wire logic temp_valid,
   input wire logic [15:0] temp_word,
   // Pins
   input wire logic [15:0] strap_oc_word,
   input wire logic enable_pin,
   input wire logic bias_ok_pin,
   input wire logic serial_alert_line_in,
   output logic serial_alert_line_out,
   output logic serial_alert_line_oe,
   // Run control
   input wire logic operation_on,
   input wire logic other_fault_off,
   // Status
   output logic output_enable,
   output logic oc_fault,
   output logic uc_fault,
   output logic ot_fault,
   output logic oc_fault_evt,
   output logic uc_fault_evt,
   output logic ot_fault_evt
);
   import ctf_pkg::*;

   // Linear-11 to fixed point; exponent plus 16 is the exponent with its sign bit flipped.
   function automatic ctf_fx_t l11_fx(input logic [15:0] w);
      logic [4:0] sh;
      sh = {~w[EXP_HI], w[EXP_HI-1:EXP_LO]};
      return ctf_fx_t'($signed(w[MANT_HI:0])) <<< sh;
   endfunction

   // Negation keeps the exponent; the most negative mantissa saturates.
   function automatic logic [15:0] l11_neg(input logic [15:0] w);
      logic [10:0] m;
      m = w[MANT_HI:0];
      return {w[EXP_HI:EXP_LO], (m == MANT_MIN) ? MANT_MAX : 11'(~m + 11'h1)};
   endfunction

   logic [15:0] oc_limit_q, uc_limit_q, ot_limit_q, ot_warn_q;
   logic [7:0] ot_action_q;
   logic [15:0] strap_s1_q, strap_s2_q;
   logic [1:0] en_sync_q, bias_sync_q;
   logic strap_loaded_q;
   logic [15:0] cmd_rdata_q;
   logic cmd_ack_q, cmd_nack_q;
   logic [RUN_W-1:0] oc_run_q, uc_run_q;
   logic oc_fault_q, uc_fault_q, ot_fault_q;
   logic oc_evt_q, uc_evt_q, ot_evt_q;
   logic ot_above_q, below_warn_q;

   ctf_seq_if seq_bus();

   // Register decode.
   wire sel_oc = cmd_code == CMD_OC_LIMIT;
   wire sel_uc = cmd_code == CMD_UC_LIMIT;
   wire sel_otl = cmd_code == CMD_OT_LIMIT;
   wire sel_ota = cmd_code == CMD_OT_ACTION;
   wire sel_otw = cmd_code == CMD_OT_WARN;
   wire cmd_known = sel_oc | sel_uc | sel_otl | sel_ota | sel_otw;
   wire wr_en = cmd_valid & cmd_write & cmd_known;
   wire [15:0] rd_mux = sel_oc ? oc_limit_q :
                        sel_uc ? uc_limit_q :
                        sel_otl ? ot_limit_q :
                        sel_otw ? ot_warn_q :
                        sel_ota ? {8'h00, ot_action_q} : 16'h0000;

   // Current comparisons.
   wire ctf_fx_t iout_fx = l11_fx(iout_word);
   wire oc_above = iout_fx > l11_fx(oc_limit_q);
   wire uc_below = iout_fx < l11_fx(uc_limit_q);
   wire cur_take = iout_valid & blank_done;
   wire [RUN_W-1:0] run_need = (consec_samples == '0) ? RUN_W'(1) : consec_samples;
   // Saturated run lengths; a plain increment would wrap and stop a long fault from tripping again.
   wire [RUN_W-1:0] oc_run_inc = (oc_run_q == '1) ? oc_run_q : oc_run_q + RUN_W'(1);
   wire [RUN_W-1:0] uc_run_inc = (uc_run_q == '1) ? uc_run_q : uc_run_q + RUN_W'(1);
   wire oc_hit = cur_take & oc_above & (oc_run_inc >= run_need);
   wire uc_hit = cur_take & uc_below & (uc_run_inc >= run_need);
   wire oc_set = oc_hit | avg_oc_trip;
   wire uc_set = uc_hit | avg_uc_trip;

   // Temperature comparisons.
   wire ctf_fx_t temp_fx = l11_fx(temp_word);
   wire temp_hot = temp_fx > l11_fx(ot_limit_q);
   wire temp_cool = temp_fx < l11_fx(ot_warn_q);

   // Pin synchronisers; the strap is static, the enables are not.
   always_ff @(posedge clk) begin
      strap_s1_q <= strap_oc_word;
      strap_s2_q <= strap_s1_q;
      en_sync_q <= {en_sync_q[0], enable_pin};
      bias_sync_q <= {bias_sync_q[0], bias_ok_pin};
   end

   // Limit registers; the strap load takes the first cycle after reset.
   always_ff @(posedge clk) begin
      if (reset) begin
         oc_limit_q <= 16'h0000;
         uc_limit_q <= 16'h0000;
         ot_limit_q <= OT_LIMIT_RST;
         ot_warn_q <= OT_WARN_RST;
         ot_action_q <= OT_ACTION_RST;
         strap_loaded_q <= 1'b0;
      end else if (!strap_loaded_q) begin
         oc_limit_q <= strap_s2_q;
         uc_limit_q <= l11_neg(strap_s2_q);
         strap_loaded_q <= 1'b1;
      end else if (wr_en) begin
         if (sel_oc) oc_limit_q <= cmd_wdata;
         if (sel_uc) uc_limit_q <= cmd_wdata;
         if (sel_otl) ot_limit_q <= cmd_wdata;
         if (sel_otw) ot_warn_q <= cmd_wdata;
         if (sel_ota) ot_action_q <= cmd_wdata[7:0];
      end
   end

   // One-cycle answer to every command.
   always_ff @(posedge clk) begin
      if (reset) begin
         cmd_rdata_q <= 16'h0000;
         cmd_ack_q <= 1'b0;
         cmd_nack_q <= 1'b0;
      end else begin
         cmd_ack_q <= cmd_valid & cmd_known;
         cmd_nack_q <= cmd_valid & ~cmd_known;
         if (cmd_valid & ~cmd_write) cmd_rdata_q <= rd_mux;
      end
   end

   // Consecutive-sample runs; blanked samples leave the runs untouched.
   always_ff @(posedge clk) begin
      if (reset) begin
         oc_run_q <= '0;
         uc_run_q <= '0;
      end else if (cur_take) begin
         oc_run_q <= oc_above ? oc_run_inc : '0;
         uc_run_q <= uc_below ? uc_run_inc : '0;
      end
   end

   // Sticky fault flags: a set in the clearing cycle wins.
   always_ff @(posedge clk) begin
      if (reset) begin
         oc_fault_q <= 1'b0;
         uc_fault_q <= 1'b0;
         ot_fault_q <= 1'b0;
         oc_evt_q <= 1'b0;
         uc_evt_q <= 1'b0;
         ot_evt_q <= 1'b0;
      end else begin
         oc_fault_q <= oc_set | (oc_fault_q & ~clear_faults);
         uc_fault_q <= uc_set | (uc_fault_q & ~clear_faults);
         ot_fault_q <= ot_above_q | (ot_fault_q & ~clear_faults);
         oc_evt_q <= oc_set;
         uc_evt_q <= uc_set;
         ot_evt_q <= seq_bus.ot_event;
      end
   end

   // Temperature levels are held between samples.
   always_ff @(posedge clk) begin
      if (reset) begin
         ot_above_q <= 1'b0;
         below_warn_q <= 1'b0;
      end else if (temp_valid) begin
         ot_above_q <= temp_hot;
         below_warn_q <= temp_cool;
      end
   end

   assign seq_bus.ot_above = ot_above_q;
   assign seq_bus.below_warn = below_warn_q;
   assign seq_bus.run_ok = en_sync_q[1] & operation_on & bias_sync_q[1] & ~other_fault_off;
   assign seq_bus.clear = clear_faults;
   assign seq_bus.action = ot_action_q;

   ctf_ot_seq #(
      .UNIT_CYC(RETRY_UNIT_CYC)
   ) u_seq (
      .clk(clk),
      .reset(reset),
      .s(seq_bus.seq)
   );

   // Alert is open drain and only ever pulls low.
   assign serial_alert_line_out = 1'b0;
   assign serial_alert_line_oe = oc_fault_q | uc_fault_q | ot_fault_q;
   assign cmd_rdata = cmd_rdata_q;
   assign cmd_ack = cmd_ack_q;
   assign cmd_nack = cmd_nack_q;
   assign output_enable = seq_bus.out_en;
   assign oc_fault = oc_fault_q;
   assign uc_fault = uc_fault_q;
   assign ot_fault = ot_fault_q;
   assign oc_fault_evt = oc_evt_q;
   assign uc_fault_evt = uc_evt_q;
   assign ot_fault_evt = ot_evt_q;

   AST_BLANK_IGNORED: assert property (
      @(posedge clk) disable iff (reset) (iout_valid && !blank_done) |=> $stable(oc_run_q) && $stable(uc_run_q))
      else $error("A blanked sample changed a consecutive run.");
   AST_OC_NEEDS_RUN: assert property (
      @(posedge clk) disable iff (reset)
      (cur_take && oc_above && !avg_oc_trip && oc_run_inc < run_need && !oc_fault_q) |=> !oc_fault_q)
      else $error("Overcurrent declared before the sample run completed.");
   AST_AVG_SHARES_OC: assert property (
      @(posedge clk) disable iff (reset) avg_oc_trip |=> oc_fault_q && oc_fault_evt)
      else $error("Averaged overcurrent did not set the shared flag.");
   AST_UC_NEEDS_RUN: assert property (
      @(posedge clk) disable iff (reset)
      (cur_take && uc_below && !avg_uc_trip && uc_run_inc < run_need && !uc_fault_q) |=> !uc_fault_q)
      else $error("Undercurrent declared before the sample run completed.");
   AST_STRAP_LOAD: assert property (
      @(posedge clk) disable iff (reset) (!strap_loaded_q) |=> uc_limit_q == l11_neg(oc_limit_q))
      else $error("Valley limit is not the negated strap limit.");
   AST_RESET_VALUES: assert property (
      @(posedge clk) disable iff (reset)
      $past(reset) |-> ot_limit_q == OT_LIMIT_RST && ot_warn_q == OT_WARN_RST && ot_action_q == OT_ACTION_RST)
      else $error("Temperature registers left reset with wrong values.");
   AST_OT_ALERT: assert property (
      @(posedge clk) disable iff (reset) ot_above_q |=> ot_fault_q && serial_alert_line_oe)
      else $error("Over-temperature did not latch the flag and alert.");
   AST_CLEAR_ONLY: assert property (
      @(posedge clk) disable iff (reset) (ot_fault_q && !clear_faults) |=> ot_fault_q)
      else $error("Over-temperature flag dropped without a clear.");
endmodule // ctf_fault_limits

// file: test/ctf_host_model.sv
// Host-side model of the command engine that reaches the fault-limit bank.
// Assumes the bank takes a request on the rising clk edge and answers one cycle later.
module ctf_host_model (
   // Clock
   input wire logic clk,
   // Request
   output logic cmd_valid,
   output logic cmd_write,
   output logic [7:0] cmd_code,
   output logic [15:0] cmd_wdata,
   // Answer
   input wire logic [15:0] cmd_rdata,
   input wire logic cmd_ack,
   input wire logic cmd_nack
);
   timeunit 1ns;
   timeprecision 1ns;

   initial begin
      cmd_valid = 1'b0;
      cmd_write = 1'b0;
      cmd_code = 8'h00;
      cmd_wdata = 16'h0000;
   end

   // One strobed access; the answer is taken at the edge after the taking edge.
   task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] wd,
                       output logic [15:0] rd, output logic [1:0] an);
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd_write <= wr;
      cmd_code <= code;
      cmd_wdata <= wd;
      @(posedge clk);
      cmd_valid <= 1'b0;
      // Released qualifiers show the inverse, so a stale value can never look valid.
      cmd_code <= ~code;
      cmd_wdata <= ~wd;
      @(posedge clk);
      rd = cmd_rdata;
      an = {cmd_ack, cmd_nack};
   endtask
endmodule // ctf_host_model

// file: test/test_ctf_fault_limits.sv
// Self-checking bench of the fault-limit register bank.
// Assumes a 20 MHz clock; the retry unit is shortened to ten cycles.
module test_ctf_fault_limits;
   timeunit 1ns;
   timeprecision 1ns;
   import ctf_pkg::*;
   localparam int unsigned UNIT = 10;
   typedef struct packed {logic wr; logic [7:0] code; logic [15:0] wd; logic [15:0] ex; logic ok;} ctf_row_t;
   logic clk, reset, clear_faults, iout_valid, blank_done, avg_oc_trip, avg_uc_trip, temp_valid;
   logic enable_pin, bias_ok_pin, operation_on, other_fault_off, cmd_valid, cmd_write, cmd_ack, cmd_nack;
   logic alert_in, serial_alert_line_out, serial_alert_line_oe, output_enable;
   logic oc_fault, uc_fault, ot_fault, oc_fault_evt, uc_fault_evt, ot_fault_evt;
   logic [15:0] iout_word, temp_word, strap_oc_word, cmd_rdata, cmd_wdata, rd;
   logic [7:0] cmd_code;
   logic [3:0] consec_samples;
   logic [1:0] an;
   int num_errors = 0;
   int n_checks = 0;
   int n;
   // Strap is 40 A, so the valley default is -40 A.
   ctf_row_t rows [12] = '{
      '{1'b0, 8'h4f, 16'h0, 16'hebe8, 1'b1}, '{1'b0, 8'h51, 16'h0, 16'heb70, 1'b1},
      '{1'b0, 8'h50, 16'h0, 16'h00bf, 1'b1}, '{1'b0, 8'h46, 16'h0, 16'h0028, 1'b1},
      '{1'b0, 8'h4b, 16'h0, 16'h07d8, 1'b1}, '{1'b1, 8'h50, 16'h00a5, 16'h0, 1'b1},
      '{1'b0, 8'h50, 16'h0, 16'h00a5, 1'b1}, '{1'b1, 8'h4b, 16'h8001, 16'h0, 1'b1},
      '{1'b0, 8'h4b, 16'h0, 16'h8001, 1'b1}, '{1'b1, 8'h4b, 16'h07d8, 16'h0, 1'b1},
      '{1'b1, 8'h99, 16'h1111, 16'h0, 1'b0}, '{1'b0, 8'h99, 16'h0, 16'h0000, 1'b0}};

   // The alert line has a pull-up, so it reads high whenever nobody pulls it.
   assign alert_in = serial_alert_line_oe ? serial_alert_line_out : 1'b1;

   ctf_fault_limits #(.RETRY_UNIT_CYC(UNIT)) i_dut (.clk, .reset, .cmd_valid, .cmd_write, .cmd_code,
      .cmd_wdata, .cmd_rdata, .cmd_ack, .cmd_nack, .clear_faults, .iout_valid, .iout_word, .blank_done,
      .consec_samples, .avg_oc_trip, .avg_uc_trip, .temp_valid, .temp_word, .strap_oc_word, .enable_pin,
      .bias_ok_pin, .serial_alert_line_in(alert_in), .serial_alert_line_out, .serial_alert_line_oe,
      .operation_on, .other_fault_off, .output_enable, .oc_fault, .uc_fault, .ot_fault, .oc_fault_evt,
      .uc_fault_evt, .ot_fault_evt);
   ctf_host_model i_host (.clk, .cmd_valid, .cmd_write, .cmd_code, .cmd_wdata, .cmd_rdata, .cmd_ack,
      .cmd_nack);

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic wt(input int k);
      repeat (k) @(posedge clk);
   endtask
   task automatic rw(input logic wr, input logic [7:0] c, input logic [15:0] d);
      i_host.xfer(wr, c, d, rd, an);
   endtask
   // Flags in the order oc, uc, ot, alert pull; the line itself must read low while pulled.
   task automatic st(input logic [3:0] e);
      chk({11'h0, oc_fault, uc_fault, ot_fault, serial_alert_line_oe, alert_in}, {11'h0, e, !e[0]});
   endtask
   task automatic smp(input logic [15:0] w, input logic b);
      @(posedge clk);
      iout_valid <= 1'b1;
      iout_word <= w;
      blank_done <= b;
      @(posedge clk);
      iout_valid <= 1'b0;
   endtask
   task automatic tmp(input logic [15:0] w);
      @(posedge clk);
      temp_valid <= 1'b1;
      temp_word <= w;
      @(posedge clk);
      temp_valid <= 1'b0;
   endtask
   task automatic clr();
      @(posedge clk);
      clear_faults <= 1'b1;
      @(posedge clk);
      clear_faults <= 1'b0;
      wt(2);
   endtask
   task automatic trip(input logic uc);
      @(posedge clk);
      avg_oc_trip <= !uc;
      avg_uc_trip <= uc;
      @(posedge clk);
      avg_oc_trip <= 1'b0;
      avg_uc_trip <= 1'b0;
      @(posedge clk);
      chk({14'h0, oc_fault_evt, uc_fault_evt}, {14'h0, !uc, uc});
      wt(1);
   endtask
   task automatic end_of_test();
      $display("checks %0d, mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      $display("mismatch at %0t: run did not finish", $time);
      end_of_test();
   end

   initial begin
      {reset, enable_pin, bias_ok_pin, operation_on} = 4'hf;
      {clear_faults, iout_valid, blank_done, avg_oc_trip, avg_uc_trip, temp_valid, other_fault_off} = 7'h0;
      consec_samples = 4'h2;
      strap_oc_word = 16'h0028;
      iout_word = 16'h0000;
      temp_word = 16'h0064;
      wt(20);
      st(4'h0);
      reset <= 1'b0;
      wt(4);
      chk({15'h0, output_enable}, 16'h1);
      foreach (rows[i]) begin
         rw(rows[i].wr, rows[i].code, rows[i].wd);
         if (!rows[i].wr) chk(rd, rows[i].ex);
         chk({14'h0, an}, {14'h0, rows[i].ok, !rows[i].ok});
      end
      $display("test registers done");
      // 41 A as 82 x 2^-1 and 39.5 A as 79 x 2^-1 exercise the exponent field.
      repeat (3) smp(16'hf852, 1'b0);
      wt(2);
      st(4'h0);
      smp(16'hf852, 1'b1);
      smp(16'hf84f, 1'b1);
      smp(16'hf852, 1'b1);
      wt(2);
      st(4'h0);
      smp(16'hf852, 1'b1);
      wt(2);
      st(4'h9);
      clr();
      st(4'h0);
      trip(1'b0);
      st(4'h9);
      clr();
      repeat (2) smp(16'hffae, 1'b0);
      smp(16'hffae, 1'b1);
      wt(2);
      st(4'h0);
      smp(16'hffae, 1'b1);
      wt(2);
      st(4'h5);
      clr();
      trip(1'b1);
      st(4'h5);
      clr();
      $display("test current done");
      // Hot is 126 C, between the limits 115 C, cool 100 C.
      for (int d = 0; d < 8; d += 7) begin
         rw(1'b1, CMD_OT_ACTION, {8'h00, 5'b10111, d[2:0]});
         tmp(16'h007e);
         wt(2);
         chk({15'h0, ot_fault_evt}, 16'h1);
         wt(3);
         st(4'h3);
         chk({15'h0, output_enable}, 16'h0);
         tmp(16'h0073);
         wt(150);
         chk({15'h0, output_enable}, 16'h0);
         tmp(16'h0064);
         n = 0;
         while (output_enable !== 1'b1 && n < 400) begin
            @(posedge clk);
            n++;
         end
         chk({15'h0, n >= (d + 1) * UNIT && n <= (d + 1) * UNIT + 4}, 16'h1);
         st(4'h3);
         clr();
         st(4'h0);
      end
      rw(1'b1, CMD_OT_ACTION, 16'h0080);
      tmp(16'h007e);
      tmp(16'h0064);
      wt(150);
      chk({15'h0, output_enable}, 16'h0);
      clr();
      wt(5);
      chk({15'h0, output_enable}, 16'h1);
      rw(1'b1, CMD_OT_ACTION, 16'h00c0);
      tmp(16'h007e);
      wt(5);
      chk({15'h0, output_enable}, 16'h0);
      tmp(16'h0073);
      wt(20);
      chk({15'h0, output_enable}, 16'h0);
      tmp(16'h0064);
      wt(5);
      chk({15'h0, output_enable}, 16'h1);
      clr();
      rw(1'b1, CMD_OT_ACTION, 16'h00b8);
      tmp(16'h007e);
      wt(5);
      enable_pin <= 1'b0;
      tmp(16'h0064);
      wt(60);
      chk({15'h0, output_enable}, 16'h0);
      enable_pin <= 1'b1;
      wt(40);
      chk({15'h0, output_enable}, 16'h1);
      clr();
      $display("test overtemp done");
      rw(1'b1, CMD_OT_LIMIT, 16'h1234);
      reset <= 1'b1;
      wt(20);
      reset <= 1'b0;
      wt(3);
      rw(1'b0, CMD_OT_LIMIT, 16'h0);
      chk(rd, 16'hebe8);
      rw(1'b0, CMD_UC_LIMIT, 16'h0);
      chk(rd, 16'h07d8);
      $display("test reset done");
      end_of_test();
   end
endmodule // test_ctf_fault_limits
